/* core/cbsl_pkg.sv */
// constants and types shared by the branch, skip and load decoder
package cbsl_pkg;
	localparam int PC_W = 22;
	localparam int BUS_AW = 8;
	localparam int CYC_W = 4;
	// opcode patterns, compared as (word & mask) == value, the indirect call as word == value
	localparam logic [15:0] MSK_BRANCH = 16'hf800;
	localparam logic [15:0] VAL_BRANCH = 16'hf000;
	localparam logic [15:0] MSK_COMPARE_SKIP_EQUAL = 16'hfc00;
	localparam logic [15:0] VAL_COMPARE_SKIP_EQUAL = 16'h1000;
	localparam logic [15:0] MSK_RSKIP = 16'hfc08;
	localparam logic [15:0] VAL_RSKIP = 16'hfc00;
	localparam logic [15:0] MSK_IOSKIP = 16'hfd00;
	localparam logic [15:0] VAL_IOSKIP = 16'h9900;
	localparam logic [15:0] VAL_EXTENDED_INDIRECT_CALL = 16'h9519;
	localparam logic [15:0] MSK_LDS = 16'hfe0f;
	localparam logic [15:0] VAL_LDS = 16'h9000;
	localparam logic [15:0] MSK_LDSTS = 16'hfc0f;
	localparam logic [15:0] MSK_JMPCALL = 16'hfe0c;
	localparam logic [15:0] VAL_JMPCALL = 16'h940c;
	// opcode field positions
	localparam int POS_POL = 10;
	localparam int POS_SKIP_POL = 9;
	localparam int POS_K_LO = 3;
	localparam int POS_K_HI = 9;
	// status register flag positions
	localparam int FLG_N = 2;
	localparam int FLG_V = 3;
	localparam int FLG_S = 4;
	// cycle figures
	localparam logic [CYC_W-1:0] CYC_ONE = 4'h1;
	localparam logic [CYC_W-1:0] CYC_TAKEN = 4'h2;
	localparam logic [CYC_W-1:0] CYC_IO_BASE = 4'h2;
	localparam logic [CYC_W-1:0] CYC_EXTENDED_INDIRECT_CALL = 4'h3;
	localparam logic [CYC_W-1:0] CYC_LDS = 4'h2;
	localparam logic [CYC_W-1:0] CYC_SKIP1 = 4'h1;
	localparam logic [CYC_W-1:0] CYC_SKIP2 = 4'h2;
	localparam logic [CYC_W-1:0] CYC_MAX = 4'hf;
	// register port offsets
	localparam logic [BUS_AW-1:0] REG_CTRL = 8'h00;
	localparam logic [BUS_AW-1:0] REG_EXT_UPPER = 8'h04;
	localparam logic [BUS_AW-1:0] REG_PC = 8'h08;
	localparam logic [BUS_AW-1:0] REG_STATE = 8'h0c;
	localparam int EXT_W = 6;
	localparam logic [EXT_W-1:0] EXT_RST = 6'h00;
	localparam logic [PC_W-1:0] PC_RST = 22'h000000;
	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_FETCH = 9'h002,
		ST_OPER = 9'h004,
		ST_EXEC = 9'h008,
		ST_SKIP_LEN = 9'h010,
		ST_LDS_K = 9'h020,
		ST_LDS_WAIT = 9'h040
	} cbsl_state_type;
endpackage : cbsl_pkg

/* core/cbsl_dec_if.sv */
// opcode and operands shared between the sequencer and its decoders
`timescale 1ns/1ps
interface cbsl_dec_if;
	logic [15:0] opcode;
	logic [7:0] status_register;
	logic [7:0] rf_a;
	logic [7:0] rf_b;
	logic [7:0] io_byte;
	logic [15:0] next_word;
	logic is_branch;
	logic is_compare_skip_equal;
	logic is_rskip;
	logic is_ioskip;
	logic is_extended_indirect_call;
	logic is_lds;
	logic branch_hit;
	logic skip_hit;
	logic two_word;
	modport seq (output opcode, status_register, rf_a, rf_b, io_byte, next_word,
		input is_branch, is_compare_skip_equal, is_rskip, is_ioskip, is_extended_indirect_call, is_lds,
		branch_hit, skip_hit, two_word);
	modport cond (input opcode, status_register, rf_a, rf_b, io_byte,
		output is_branch, is_compare_skip_equal, is_rskip, is_ioskip, is_extended_indirect_call, is_lds,
		branch_hit, skip_hit);
	modport len (input next_word, output two_word);
endinterface : cbsl_dec_if

/* core/cbsl_cond_eval.sv */
// class decode and branch or skip condition of one opcode
`timescale 1ns/1ps
module cbsl_cond_eval
	import cbsl_pkg::*;
(
	cbsl_dec_if.cond dec
);
	logic flag;
	logic [2:0] sel;
	always_comb
	begin
		sel = dec.opcode[2:0];
		dec.is_branch = (dec.opcode & MSK_BRANCH) == VAL_BRANCH;
		dec.is_compare_skip_equal = (dec.opcode & MSK_COMPARE_SKIP_EQUAL) == VAL_COMPARE_SKIP_EQUAL;
		dec.is_rskip = (dec.opcode & MSK_RSKIP) == VAL_RSKIP;
		dec.is_ioskip = (dec.opcode & MSK_IOSKIP) == VAL_IOSKIP;
		dec.is_extended_indirect_call = dec.opcode == VAL_EXTENDED_INDIRECT_CALL;
		dec.is_lds = (dec.opcode & MSK_LDS) == VAL_LDS;
		// signed tests look at n xor v, not at a stored sign flag
		if (sel == 3'(FLG_S))
			flag = dec.status_register[FLG_N] ^ dec.status_register[FLG_V];
		else
			flag = dec.status_register[sel];
		dec.branch_hit = dec.opcode[POS_POL] ? ~flag : flag;
		if (dec.is_compare_skip_equal)
			dec.skip_hit = dec.rf_a == dec.rf_b;
		else if (dec.is_rskip)
			dec.skip_hit = dec.rf_a[sel] == dec.opcode[POS_SKIP_POL];
		else if (dec.is_ioskip)
			dec.skip_hit = dec.io_byte[sel] == dec.opcode[POS_SKIP_POL];
		else
			dec.skip_hit = 1'b0;
	end
endmodule : cbsl_cond_eval

/* core/cbsl_word_len.sv */
// tells whether a fetched word opens a two-word instruction
`timescale 1ns/1ps
module cbsl_word_len
	import cbsl_pkg::*;
(
	cbsl_dec_if.len dec
);
	always_comb
	begin
		dec.two_word = ((dec.next_word & MSK_LDSTS) == VAL_LDS)
			|| ((dec.next_word & MSK_JMPCALL) == VAL_JMPCALL);
	end
endmodule : cbsl_word_len

/* core/cbsl_top.sv */
// branch, skip, indirect call and direct load sequencer
// Function
// - indirect call loads pc from z and upper
// - equal registers skip next instruction, flags kept
// - register bit test skips on chosen polarity
// - io bit test skips, two to four cycles
// - status bit branch jumps to pc+k+1
// - signed branches test n xor v
// - unsigned branches test carry flag
// - half carry branches test h flag
// - transfer branches test t, flags untouched
// - overflow branches test v flag
// - interrupt branches test global interrupt flag
// - carry clear branch jumps when c zero
// - direct load copies data byte into rd
`timescale 1ns/1ps
module cbsl_top
	import cbsl_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic [BUS_AW-1:0] i_bus_addr,
	input wire logic [31:0] i_bus_wdata,
	input wire logic i_bus_wr,
	input wire logic i_bus_rd,
	output logic [31:0] o_bus_rdata,
	output logic [PC_W-1:0] o_pm_addr,
	input wire logic [15:0] i_pm_data,
	input wire logic [7:0] i_status_register,
	input wire logic [15:0] i_z_ptr,
	output logic [4:0] o_rf_raddr_a,
	output logic [4:0] o_rf_raddr_b,
	input wire logic [7:0] i_rf_rdata_a,
	input wire logic [7:0] i_rf_rdata_b,
	output logic [4:0] o_io_addr,
	input wire logic [7:0] i_io_rdata,
	output logic [15:0] o_ds_addr,
	output logic o_ds_rd,
	input wire logic i_ds_ready,
	input wire logic [7:0] i_ds_rdata,
	output logic o_rf_we,
	output logic [4:0] o_rf_waddr,
	output logic [7:0] o_rf_wdata,
	output logic o_push,
	output logic [PC_W-1:0] o_push_pc,
	output logic o_retire,
	output logic [CYC_W-1:0] o_retire_cycles,
	output logic [PC_W-1:0] o_pc
);
	////////////////////////////////////////////////////////////////////////////
	cbsl_dec_if dec ();
	cbsl_cond_eval u_cond (.dec(dec));
	cbsl_word_len u_len (.dec(dec));

	cbsl_state_type state_q, state_d;
	logic [PC_W-1:0] pc_q, pc_d;
	logic [15:0] op_q, op_d;
	logic [CYC_W-1:0] base_q, base_d;
	logic [CYC_W-1:0] wait_q, wait_d;
	logic [PC_W-1:0] pm_addr_q, pm_addr_d;
	logic [4:0] ra_q, ra_d, rb_q, rb_d, io_q, io_d;
	logic [15:0] ds_addr_q, ds_addr_d;
	logic ds_rd_q, ds_rd_d;
	logic we_q, we_d;
	logic [7:0] wdata_q, wdata_d;
	logic push_q, push_d;
	logic [PC_W-1:0] push_pc_q, push_pc_d;
	logic ret_q, ret_d;
	logic [CYC_W-1:0] cyc_q, cyc_d;
	logic run_q, run_d;
	logic [EXT_W-1:0] ext_upper_q, ext_upper_d;
	logic [31:0] rdata_q, rdata_d;
	logic [PC_W-1:0] rel_k;
	logic [PC_W-1:0] pc_next;

	assign dec.opcode = op_q;
	assign dec.status_register = i_status_register;
	assign dec.rf_a = i_rf_rdata_a;
	assign dec.rf_b = i_rf_rdata_b;
	assign dec.io_byte = i_io_rdata;
	assign dec.next_word = i_pm_data;

	////////////////////////////////////////////////////////////////////////////
	// instruction sequencer
	always_comb
	begin
		state_d = state_q;
		pc_d = pc_q;
		op_d = op_q;
		base_d = base_q;
		wait_d = wait_q;
		pm_addr_d = pm_addr_q;
		ra_d = ra_q;
		rb_d = rb_q;
		io_d = io_q;
		ds_addr_d = ds_addr_q;
		ds_rd_d = 1'b0;
		we_d = 1'b0;
		wdata_d = wdata_q;
		push_d = 1'b0;
		push_pc_d = push_pc_q;
		ret_d = 1'b0;
		cyc_d = cyc_q;
		pc_next = pc_q + 22'h000001;
		rel_k = PC_W'($signed(op_q[POS_K_HI:POS_K_LO]));
		// software writes the pc only while the sequencer rests
		if (state_q == ST_IDLE && i_bus_wr && i_bus_addr == REG_PC)
			pc_d = i_bus_wdata[PC_W-1:0];
		unique case (state_q)
			ST_IDLE:
			begin
				if (run_q)
					state_d = ST_FETCH;
			end
			ST_FETCH:
			begin
				pm_addr_d = pc_q;
				state_d = ST_OPER;
			end
			ST_OPER:
			begin
				// operands are requested here so they stand in the next cycle
				op_d = i_pm_data;
				ra_d = i_pm_data[8:4];
				rb_d = {i_pm_data[9], i_pm_data[3:0]};
				io_d = i_pm_data[7:3];
				state_d = ST_EXEC;
			end
			ST_EXEC:
			begin
				state_d = run_q ? ST_FETCH : ST_IDLE;
				if (dec.is_branch)
				begin
					ret_d = 1'b1;
					if (dec.branch_hit)
					begin
						pc_d = pc_next + rel_k;
						cyc_d = CYC_TAKEN;
					end
					else
					begin
						pc_d = pc_next;
						cyc_d = CYC_ONE;
					end
				end
				else if (dec.is_compare_skip_equal || dec.is_rskip || dec.is_ioskip)
				begin
					base_d = dec.is_ioskip ? CYC_IO_BASE : CYC_ONE;
					if (dec.skip_hit)
					begin
						pm_addr_d = pc_next;
						state_d = ST_SKIP_LEN;
					end
					else
					begin
						pc_d = pc_next;
						ret_d = 1'b1;
						cyc_d = base_d;
					end
				end
				else if (dec.is_extended_indirect_call)
				begin
					pc_d = {ext_upper_q, i_z_ptr};
					push_d = 1'b1;
					push_pc_d = pc_next;
					ret_d = 1'b1;
					cyc_d = CYC_EXTENDED_INDIRECT_CALL;
				end
				else if (dec.is_lds)
				begin
					pm_addr_d = pc_next;
					state_d = ST_LDS_K;
				end
				else
				begin
					// words outside this decoder pass as single-word no-ops
					pc_d = pc_next;
					ret_d = 1'b1;
					cyc_d = CYC_ONE;
				end
			end
			ST_SKIP_LEN:
			begin
				// the skipped word decides whether two or three words go by
				pc_d = pc_q + (dec.two_word ? 22'h000003 : 22'h000002);
				cyc_d = base_q + (dec.two_word ? CYC_SKIP2 : CYC_SKIP1);
				ret_d = 1'b1;
				state_d = run_q ? ST_FETCH : ST_IDLE;
			end
			ST_LDS_K:
			begin
				ds_addr_d = i_pm_data;
				ds_rd_d = 1'b1;
				wait_d = CYC_LDS;
				state_d = ST_LDS_WAIT;
			end
			ST_LDS_WAIT:
			begin
				// the request cycle is not counted, data can only follow it
				if (!ds_rd_q && i_ds_ready)
				begin
					we_d = 1'b1;
					wdata_d = i_ds_rdata;
					pc_d = pc_q + 22'h000002;
					ret_d = 1'b1;
					cyc_d = wait_q;
					state_d = run_q ? ST_FETCH : ST_IDLE;
				end
				else if (!ds_rd_q && wait_q != CYC_MAX)
					wait_d = wait_q + CYC_ONE; // slow memory stretches the count
			end
			default:
				state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			state_q <= ST_IDLE;
			pc_q <= PC_RST;
			op_q <= 16'h0000;
			base_q <= CYC_ONE;
			wait_q <= CYC_LDS;
			pm_addr_q <= PC_RST;
			ra_q <= 5'h00;
			rb_q <= 5'h00;
			io_q <= 5'h00;
			ds_addr_q <= 16'h0000;
			ds_rd_q <= 1'b0;
			we_q <= 1'b0;
			wdata_q <= 8'h00;
			push_q <= 1'b0;
			push_pc_q <= PC_RST;
			ret_q <= 1'b0;
			cyc_q <= 4'h0;
		end
		else
		begin
			state_q <= state_d;
			pc_q <= pc_d;
			op_q <= op_d;
			base_q <= base_d;
			wait_q <= wait_d;
			pm_addr_q <= pm_addr_d;
			ra_q <= ra_d;
			rb_q <= rb_d;
			io_q <= io_d;
			ds_addr_q <= ds_addr_d;
			ds_rd_q <= ds_rd_d;
			we_q <= we_d;
			wdata_q <= wdata_d;
			push_q <= push_d;
			push_pc_q <= push_pc_d;
			ret_q <= ret_d;
			cyc_q <= cyc_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// register port
	always_comb
	begin
		run_d = run_q;
		ext_upper_d = ext_upper_q;
		rdata_d = 32'h00000000;
		if (i_bus_wr)
		begin
			if (i_bus_addr == REG_CTRL)
				run_d = i_bus_wdata[0];
			if (i_bus_addr == REG_EXT_UPPER)
				ext_upper_d = i_bus_wdata[EXT_W-1:0];
		end
		if (i_bus_rd)
		begin
			unique case (i_bus_addr)
				REG_CTRL: rdata_d = {31'h00000000, run_q};
				REG_EXT_UPPER: rdata_d = {26'h0000000, ext_upper_q};
				REG_PC: rdata_d = {10'h000, pc_q};
				REG_STATE: rdata_d = {19'h00000, cyc_q, state_q};
				default: rdata_d = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			run_q <= 1'b0;
			ext_upper_q <= EXT_RST;
			rdata_q <= 32'h00000000;
		end
		else
		begin
			run_q <= run_d;
			ext_upper_q <= ext_upper_d;
			rdata_q <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// the status register is only read here, never written back
	assign o_bus_rdata = rdata_q;
	assign o_pm_addr = pm_addr_q;
	assign o_rf_raddr_a = ra_q;
	assign o_rf_raddr_b = rb_q;
	assign o_io_addr = io_q;
	assign o_ds_addr = ds_addr_q;
	assign o_ds_rd = ds_rd_q;
	assign o_rf_we = we_q;
	assign o_rf_waddr = ra_q;
	assign o_rf_wdata = wdata_q;
	assign o_push = push_q;
	assign o_push_pc = push_pc_q;
	assign o_retire = ret_q;
	assign o_retire_cycles = cyc_q;
	assign o_pc = pc_q;
endmodule : cbsl_top

/* testbench/cbsl_props.sv */
// assertions on the top ports of the sequencer
`timescale 1ns/1ps
module cbsl_props
	import cbsl_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_bus_rd,
	input wire logic i_bus_wr,
	input wire logic [31:0] o_bus_rdata,
	input wire logic [15:0] i_z_ptr,
	input wire logic o_ds_rd,
	input wire logic i_ds_ready,
	input wire logic [7:0] i_ds_rdata,
	input wire logic o_rf_we,
	input wire logic [7:0] o_rf_wdata,
	input wire logic o_push,
	input wire logic o_retire,
	input wire logic [CYC_W-1:0] o_retire_cycles,
	input wire logic [PC_W-1:0] o_pc
);
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_resetn);
	////////////////////////////////////////////////////////////////////////////////
	a_rdata_gap: assert property (!$past(i_bus_rd) |-> o_bus_rdata == 32'h0)
		else $error("read data outside its slot");
	a_retire_once: assert property (o_retire |=> !o_retire)
		else $error("retire longer than one cycle");
	a_step_one: assert property (o_retire && o_retire_cycles == 4'h1 |-> o_pc == $past(o_pc) + 22'h1)
		else $error("one cycle retire not pc plus one");
	// pc may only move at retire or after a bus write
	a_pc_hold: assert property (!o_retire && !$past(i_bus_wr) |-> $stable(o_pc))
		else $error("pc moved without retire");
	a_call_z: assert property (o_push |-> ##[0:3] (o_retire && o_pc[15:0] == i_z_ptr))
		else $error("indirect call target wrong");
	a_load_gap: assert property (o_ds_rd |=> !o_ds_rd ##[1:19] o_rf_we)
		else $error("load never wrote the register");
	a_load_fast: assert property (o_ds_rd ##1 i_ds_ready |=> o_rf_we && o_retire_cycles == 4'h2)
		else $error("fast load not two cycles");
	a_load_data: assert property (o_rf_we |-> o_retire && o_rf_wdata == $past(i_ds_rdata))
		else $error("loaded byte wrong");
	a_load_pc: assert property (o_rf_we |-> o_pc == $past(o_pc) + 22'h2)
		else $error("load pc not plus two");
	c_taken: cover property (o_retire && o_retire_cycles == 4'h2);
	c_skip_long: cover property (o_retire && o_retire_cycles == 4'h4);
	c_slow_load: cover property (o_rf_we && o_retire_cycles == 4'h5);
endmodule : cbsl_props

bind cbsl_top cbsl_props cbsl_props_inst (.*);

/* testbench/cbsl_mem_model.sv */
// program memory, register file, io and data space beside the core
`timescale 1ns/1ps
module cbsl_mem_model
	import cbsl_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic [PC_W-1:0] o_pm_addr,
	input wire logic [4:0] o_rf_raddr_a,
	input wire logic [4:0] o_rf_raddr_b,
	input wire logic [4:0] o_io_addr,
	input wire logic [15:0] o_ds_addr,
	input wire logic o_ds_rd,
	input wire logic [3:0] ds_wait,
	output logic [15:0] i_pm_data,
	output logic [7:0] i_rf_rdata_a,
	output logic [7:0] i_rf_rdata_b,
	output logic [7:0] i_io_rdata,
	output logic i_ds_ready,
	output logic [7:0] i_ds_rdata
);
	logic [15:0] pm [64];
	logic [7:0] rf [32];
	logic [7:0] io [32];
	logic [15:0] ds_a_q;
	logic [3:0] cnt_q;
	logic busy_q;
	logic [7:0] ds_byte;
	initial
	begin
		for (int i = 0; i < 64; i++)
		begin
			pm[i] = 16'h0000;
			rf[i[4:0]] = 8'h00;
			io[i[4:0]] = 8'h00;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// addresses are registered in the core, so reads here are plain lookups
	assign i_pm_data = pm[o_pm_addr[5:0]];
	assign i_rf_rdata_a = rf[o_rf_raddr_a];
	assign i_rf_rdata_b = rf[o_rf_raddr_b];
	assign i_io_rdata = io[o_io_addr];
	assign ds_byte = ds_a_q[7:0] ^ 8'h5a;
	assign i_ds_ready = busy_q && cnt_q == 4'h0;
	// inverted byte while not ready, so a stale sample cannot pass
	assign i_ds_rdata = i_ds_ready ? ds_byte : ~ds_byte;
	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			busy_q <= 1'b0;
			cnt_q <= 4'h0;
			ds_a_q <= 16'h0000;
		end
		else if (o_ds_rd)
		begin
			busy_q <= 1'b1;
			cnt_q <= ds_wait;
			ds_a_q <= o_ds_addr;
		end
		else if (busy_q)
		begin
			if (cnt_q == 4'h0)
				busy_q <= 1'b0;
			else
				cnt_q <= cnt_q - 4'h1;
		end
	end
endmodule : cbsl_mem_model

/* testbench/testbench.sv */
// self-checking bench for the branch, skip and load sequencer
`timescale 1ns/1ps
module testbench
	import cbsl_pkg::*;
;
	localparam logic [PC_W-1:0] BASE = 22'h000010;
	localparam logic [7:0] SR [6] = '{8'h00, 8'hff, 8'h5a, 8'ha5, 8'h04, 8'h08};
	logic i_sys_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic i_bus_wr = 1'b0;
	logic i_bus_rd = 1'b0;
	logic [BUS_AW-1:0] i_bus_addr = 8'h00;
	logic [31:0] i_bus_wdata = 32'h0;
	logic [7:0] i_status_register = 8'h00;
	logic [15:0] i_z_ptr = 16'hbeef;
	logic [3:0] ds_wait = 4'h0;
	logic [31:0] o_bus_rdata;
	logic [PC_W-1:0] o_pm_addr, o_push_pc, o_pc;
	logic [15:0] i_pm_data, o_ds_addr;
	logic [4:0] o_rf_raddr_a, o_rf_raddr_b, o_io_addr, o_rf_waddr;
	logic [7:0] i_rf_rdata_a, i_rf_rdata_b, i_io_rdata, i_ds_rdata, o_rf_wdata;
	logic o_ds_rd, i_ds_ready, o_rf_we, o_push, o_retire;
	logic [CYC_W-1:0] o_retire_cycles;
	int bad_count = 0;
	int num_checks = 0;
	always #2.5 i_sys_clk = ~i_sys_clk;
	cbsl_top cbsl_top_inst (.*);
	cbsl_mem_model cbsl_mem_model_inst (.*);
	////////////////////////////////////////////////////////////////////////////////
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	task tally_and_finish;
		$display("checks %0d errors %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish
	// strobe dropped and one edge let pass, so calls never collide
	task wr(input logic [7:0] a, input logic [31:0] d);
		i_bus_addr <= a;
		i_bus_wdata <= d;
		i_bus_wr <= 1'b1;
		@(posedge i_sys_clk);
		i_bus_wr <= 1'b0;
		@(posedge i_sys_clk);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e);
		i_bus_addr <= a;
		i_bus_rd <= 1'b1;
		@(posedge i_sys_clk);
		i_bus_rd <= 1'b0;
		#1 cmp(o_bus_rdata, e);
		@(posedge i_sys_clk);
	endtask : rd
	// one instruction: run raised then dropped, so the core idles after it
	task run(input logic [15:0] op, input logic [15:0] nx, input logic [PC_W-1:0] off,
		input logic [3:0] cyc);
		int n;
		n = 0;
		cbsl_mem_model_inst.pm[16] = op;
		cbsl_mem_model_inst.pm[17] = nx;
		wr(REG_PC, 32'(BASE));
		wr(REG_CTRL, 32'h1);
		wr(REG_CTRL, 32'h0);
		#1;
		while (o_retire !== 1'b1 && n < 40)
		begin
			@(posedge i_sys_clk);
			#1 n++;
		end
		cmp(o_retire, 32'h1);
		cmp(o_retire_cycles, cyc);
		cmp(o_pc, 22'(BASE + off));
		cmp(o_push, 32'(op == 16'h9519));
		if (op == 16'h9519)
			cmp(o_push_pc, 32'(BASE + 22'h1));
		if (op == 16'h90d0)
		begin
			cmp(o_rf_waddr, 32'hd);
			cmp(o_rf_wdata, 32'h6e);
		end
		repeat (2) @(posedge i_sys_clk);
	endtask : run
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		logic [6:0] k;
		logic [15:0] op;
		logic fl;
		logic bt;
		repeat (3) @(posedge i_sys_clk);
		i_resetn <= 1'b1;
		@(posedge i_sys_clk);
		rd(REG_PC, 32'h0);
		rd(REG_CTRL, 32'h0);
		rd(REG_EXT_UPPER, 32'h0);
		rd(8'h20, 32'h0);
		wr(REG_EXT_UPPER, 32'h2a);
		rd(REG_EXT_UPPER, 32'h2a);
		run(16'h9519, 16'h0, 22'({6'h2a, 16'hbeef} - BASE), 4'h3);
		for (int j = 0; j < 6; j++)
			for (int s = 0; s < 8; s++)
				for (int p = 0; p < 2; p++)
				begin
					k = 7'(s * 19 + p * 40 + j);
					i_status_register <= SR[j];
					fl = (s == 4) ? SR[j][2] ^ SR[j][3] : SR[j][s];
					op = 16'hf000 | 16'(p << 10) | (16'(k) << 3) | 16'(s);
					run(op, 16'h0, (fl ^ p[0]) ? 22'h1 + {{15{k[6]}}, k} : 22'h1,
						(fl ^ p[0]) ? 4'h2 : 4'h1);
				end
		for (int kd = 0; kd < 3; kd++)
			for (int p = 0; p < 2; p++)
				for (int h = 0; h < 2; h++)
					for (int t = 0; t < 2; t++)
					begin
						bt = (h != 0) ? p[0] : !p[0];
						cbsl_mem_model_inst.rf[5] = bt ? 8'h3c : 8'h34;
						cbsl_mem_model_inst.rf[18] = cbsl_mem_model_inst.rf[5] ^ 8'(h == 0);
						cbsl_mem_model_inst.io[7] = bt ? 8'h40 : 8'hbf;
						op = (kd == 0) ? 16'h1252 : (kd == 1) ? 16'hfc53 : 16'h993e;
						if (kd > 0)
							op[9] = p[0];
						run(op, (t != 0) ? 16'h9000 : 16'h0000, (h != 0) ? 22'(2 + t) : 22'h1,
							4'(1 + (kd == 2) + ((h != 0) ? 1 + t : 0)));
					end
		for (int w = 0; w < 2; w++)
		begin
			ds_wait <= 4'(3 * w);
			run(16'h90d0, 16'h1234, 22'h2, 4'(2 + 3 * w));
		end
		rd(REG_PC, 32'(BASE + 22'h2));
		// last load reported five cycles, sequencer back at rest
		rd(REG_STATE, 32'h00000a01);
		tally_and_finish();
	end
	initial
	begin
		#100000;
		bad_count++;
		tally_and_finish();
	end
endmodule : testbench
